// ===== ttled_cond_eval.v
// per-led illumination condition: and terms gating an or of terms over optionally inverted logic bits
`timescale 1ns/1ps
`default_nettype none
`include "ttled_consts.vh"
module ttled_cond_eval (
  input  wire                         mclk,
  input  wire                         rst_b,
  input  wire [`TTLED_NUM_BITS-1:0]   logic_bits,
  input  wire [`TTLED_NUM_BITS-1:0]   term_use,
  input  wire [`TTLED_NUM_BITS-1:0]   term_inv,
  input  wire [`TTLED_NUM_BITS-1:0]   term_and,
  output reg                          cond_q
);
  reg [`TTLED_NUM_BITS-1:0] lit;
  reg                       or_v;
  reg                       and_v;
  reg                       any_v;
  integer i;
  always @* begin
    lit   = logic_bits ^ term_inv;
    or_v  = 1'b0;
    and_v = 1'b1;
    any_v = 1'b0;
    for (i = 0; i < `TTLED_NUM_BITS; i = i + 1) begin
      if (term_use[i] && !term_and[i]) begin
        or_v = or_v | lit[i];
      end
      if (term_use[i] && term_and[i]) begin
        and_v = and_v & lit[i];
        any_v = 1'b1;
      end
    end
  end
  // and group gates or group; empty or group with and terms means and alone
  always @(posedge mclk) begin
    if (!rst_b) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= any_v ? (and_v & (or_v | ~|(term_use & ~term_and))) : or_v;
    end
  end
endmodule
`default_nettype wire

// ===== ttled_consts.vh
// constants for the trip target led logic
`ifndef TTLED_CONSTS_VH
`define TTLED_CONSTS_VH
`define TTLED_NUM_LEDS      12
`define TTLED_NUM_BITS      16
`define TTLED_IDX_W         4
`define TTLED_MODE_STATUS   1'b0
`define TTLED_MODE_TARGET   1'b1
`define TTLED_ROC_N         2'h0
`define TTLED_ROC_N1        2'h1
`define TTLED_ROC_Y         2'h2
`define TTLED_ROC_Y1        2'h3
`endif

// ===== ttled_props.sv
// checker for the trip target led logic
`timescale 1ns/1ps
`default_nettype none
module ttled_props (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [15:0] logic_bits,
  input wire logic [11:0] led_latch_mode_select,
  input wire logic [1:0]  reset_on_close_sel,
  input wire logic        trip_in,
  input wire logic        target_reset_pb,
  input wire logic        close_in,
  input wire logic        control_enabled_in,
  input wire logic [2:0]  phase_fault_in,
  input wire logic [11:0] led_out_q,
  input wire logic        control_enabled_led_q,
  input wire logic [2:0]  phase_target_led_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [7:0] t_q;
  logic [7:0] e_q;
  wire  [11:0] m = led_latch_mode_select;
  always @(posedge mclk) begin
    t_q <= {t_q[6:0], trip_in};
    e_q <= {e_q[6:0], trip_in | target_reset_pb | close_in & reset_on_close_sel[1]};
  end
  property p_on(int i);
    $rose(led_out_q[i]) && $past(m[i]) && $past(m[i], 2) |-> |(t_q[5:3] & ~t_q[6:4]);
  endproperty
  property p_off(int i);
    $fell(led_out_q[i]) && $past(m[i]) && $past(m[i], 2) |-> |e_q;
  endproperty
  tgt_on_lo_a: assert property (p_on(0)) else $error("led 0 lit without trip");
  tgt_on_hi_a: assert property (p_on(11)) else $error("led 11 lit without trip");
  tgt_off_lo_a: assert property (p_off(0)) else $error("led 0 cleared early");
  tgt_off_hi_a: assert property (p_off(11)) else $error("led 11 cleared early");
  stat_follow_a: assert property ($changed(led_out_q[0]) && !$past(m[0]) &&
    !$past(m[0], 2) && $past(rst_b, 6) |-> $past(logic_bits, 4) != $past(logic_bits, 5))
    else $error("status led moved alone");
  fixed_ce_a: assert property ($past(rst_b) |->
    control_enabled_led_q == $past(control_enabled_in)) else $error("enabled led wrong");
  fixed_ph_a: assert property ($past(rst_b) |->
    phase_target_led_q == $past(phase_fault_in)) else $error("phase led wrong");
  reset_dark_a: assert property (disable iff (1'b0) !rst_b |=> led_out_q == 12'h000)
    else $error("led lit in reset");
  cover property (m[0] && $rose(led_out_q[0]));
  cover property (m[0] && $fell(led_out_q[0]));
  cover property (!m[0] && $changed(led_out_q[0]));
endmodule
bind ttled_top ttled_props u_props (.*);
`default_nettype wire

// ===== ttled_src.sv
// model of the protection logic and pushbutton feeding the leds
`timescale 1ns/1ps
`default_nettype none
module ttled_src (
  input  wire logic        mclk,
  input  wire logic [18:0] req,
  output var  logic [15:0] logic_bits,
  output var  logic        trip_in,
  output var  logic        target_reset_pb,
  output var  logic        close_in
);
  initial {close_in, target_reset_pb, trip_in, logic_bits} = 19'h00000;
  // levels move just after the edge and hold until the next request
  always @(posedge mclk) #1 {close_in, target_reset_pb, trip_in, logic_bits} <= req;
endmodule
`default_nettype wire

// ===== ttled_top.v
// front-panel programmable status and trip target led logic
`timescale 1ns/1ps
`default_nettype none
`include "ttled_consts.vh"
module ttled_top (
  input  wire                                         mclk,
  input  wire                                         rst_b,
  input  wire [`TTLED_NUM_BITS-1:0]                   logic_bits,
  input  wire [`TTLED_NUM_LEDS*`TTLED_NUM_BITS-1:0]   term_use,
  input  wire [`TTLED_NUM_LEDS*`TTLED_NUM_BITS-1:0]   term_inv,
  input  wire [`TTLED_NUM_LEDS*`TTLED_NUM_BITS-1:0]   term_and,
  input  wire [`TTLED_NUM_LEDS-1:0]                   led_latch_mode_select,
  input  wire [1:0]                                   reset_on_close_sel,
  input  wire                                         trip_in,
  input  wire                                         target_reset_pb,
  input  wire                                         close_in,
  input  wire                                         control_enabled_in,
  input  wire [2:0]                                   phase_fault_in,
  output reg  [`TTLED_NUM_LEDS-1:0]                   led_out_q,
  output reg                                          control_enabled_led_q,
  output reg  [2:0]                                   phase_target_led_q
);
  //////////////////////////////////////////////////////////////////////////////
  // edge detection shared by the three event pins
  function is_rise;
    input now_v;
    input was_v;
    begin
      is_rise = now_v & ~was_v;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // trip pin synchroniser and edge detector
  // a trip held high across reset release counts as a fresh edge
  reg [1:0] trip_s_q;
  reg       trip_prev_q;
  wire      trip_rise;
  always @(posedge mclk) begin
    if (!rst_b) begin
      trip_s_q    <= 2'h0;
      trip_prev_q <= 1'b0;
    end else begin
      trip_s_q    <= {trip_s_q[0], trip_in};
      trip_prev_q <= trip_s_q[1];
    end
  end
  assign trip_rise = is_rise(trip_s_q[1], trip_prev_q);

  //////////////////////////////////////////////////////////////////////////////
  // target reset pushbutton synchroniser and edge detector
  reg [1:0] pb_s_q;
  reg       pb_prev_q;
  wire      pb_rise;
  always @(posedge mclk) begin
    if (!rst_b) begin
      pb_s_q    <= 2'h0;
      pb_prev_q <= 1'b0;
    end else begin
      pb_s_q    <= {pb_s_q[0], target_reset_pb};
      pb_prev_q <= pb_s_q[1];
    end
  end
  assign pb_rise = is_rise(pb_s_q[1], pb_prev_q);

  //////////////////////////////////////////////////////////////////////////////
  // close pin synchroniser and edge detector
  reg [1:0] cls_s_q;
  reg       cls_prev_q;
  wire      cls_rise;
  always @(posedge mclk) begin
    if (!rst_b) begin
      cls_s_q    <= 2'h0;
      cls_prev_q <= 1'b0;
    end else begin
      cls_s_q    <= {cls_s_q[0], close_in};
      cls_prev_q <= cls_s_q[1];
    end
  end
  assign cls_rise = is_rise(cls_s_q[1], cls_prev_q);

  //////////////////////////////////////////////////////////////////////////////
  // logic bit synchroniser
  // same two-flop depth as the event pins
  reg [`TTLED_NUM_BITS-1:0] bits_s1_q;
  reg [`TTLED_NUM_BITS-1:0] bits_s2_q;
  always @(posedge mclk) begin
    if (!rst_b) begin
      bits_s1_q <= {`TTLED_NUM_BITS{1'b0}};
      bits_s2_q <= {`TTLED_NUM_BITS{1'b0}};
    end else begin
      bits_s1_q <= logic_bits;
      bits_s2_q <= bits_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event alignment
  // edges wait one cycle so they line up with the registered conditions
  reg trip_rise_q;
  reg pb_rise_q;
  reg cls_rise_q;
  always @(posedge mclk) begin
    if (!rst_b) begin
      trip_rise_q <= 1'b0;
      pb_rise_q   <= 1'b0;
      cls_rise_q  <= 1'b0;
    end else begin
      trip_rise_q <= trip_rise;
      pb_rise_q   <= pb_rise;
      cls_rise_q  <= cls_rise;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // condition evaluation, one per programmable led
  // each evaluator registers its result once
  wire [`TTLED_NUM_LEDS-1:0] cond;
  genvar g;
  generate
    for (g = 0; g < `TTLED_NUM_LEDS; g = g + 1) begin : g_led
      ttled_cond_eval u_cond (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .logic_bits (bits_s2_q),
        .term_use   (term_use[g*`TTLED_NUM_BITS +: `TTLED_NUM_BITS]),
        .term_inv   (term_inv[g*`TTLED_NUM_BITS +: `TTLED_NUM_BITS]),
        .term_and   (term_and[g*`TTLED_NUM_BITS +: `TTLED_NUM_BITS]),
        .cond_q     (cond[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // event decode
  function roc_clears;
    input [1:0] sel;
    begin
      roc_clears = (sel == `TTLED_ROC_Y) || (sel == `TTLED_ROC_Y1);
    end
  endfunction

  wire close_clear;
  wire evt_sample;
  wire evt_clear;
  // trip wins over the pushbutton and over close; the pushbutton and close clear alike
  // close clears only for reset-on-close y or y1
  assign close_clear = cls_rise_q & roc_clears(reset_on_close_sel);
  assign evt_sample  = trip_rise_q;
  assign evt_clear   = ~trip_rise_q & (pb_rise_q | close_clear);

  //////////////////////////////////////////////////////////////////////////////
  // trip target latch
  // a trip re-evaluates every led, so a lit led may go dark
  reg [`TTLED_NUM_LEDS-1:0] latch_q;
  reg [`TTLED_NUM_LEDS-1:0] latch_d;
  always @* begin
    if (evt_sample) begin
      latch_d = cond;
    end else if (evt_clear) begin
      latch_d = {`TTLED_NUM_LEDS{1'b0}};
    end else begin
      latch_d = latch_q;
    end
  end
  always @(posedge mclk) begin
    if (!rst_b) begin
      latch_q <= {`TTLED_NUM_LEDS{1'b0}};
    end else begin
      latch_q <= latch_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // programmable led outputs
  // a mode change shows at the next edge; latch state is kept meanwhile
  function led_pick;
    input mode_v;
    input cond_v;
    input latch_v;
    begin
      led_pick = (mode_v == `TTLED_MODE_STATUS) ? cond_v : latch_v;
    end
  endfunction

  integer k;
  always @(posedge mclk) begin
    if (!rst_b) begin
      led_out_q <= {`TTLED_NUM_LEDS{1'b0}};
    end else begin
      for (k = 0; k < `TTLED_NUM_LEDS; k = k + 1) begin
        led_out_q[k] <= led_pick(led_latch_mode_select[k], cond[k], latch_d[k]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fixed control-enabled led
  always @(posedge mclk) begin
    if (!rst_b) begin
      control_enabled_led_q <= 1'b0;
    end else begin
      control_enabled_led_q <= control_enabled_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fixed phase fault-type leds
  always @(posedge mclk) begin
    if (!rst_b) begin
      phase_target_led_q <= 3'h0;
    end else begin
      phase_target_led_q <= phase_fault_in;
    end
  end
endmodule
`default_nettype wire

// ===== ttled_top_tb.sv
// testbench for the trip target led logic
`timescale 1ns/1ps
`default_nettype none
module ttled_top_tb;
  logic         mclk = 0, rst_b = 0, ce = 0, trip, pb, cls;
  logic [18:0]  req = 19'h00000;
  logic [15:0]  bits;
  logic [11:0]  mode = 12'h000, lat = 12'h000, xl;
  logic [1:0]   roc = 2'h0;
  logic [2:0]   ph = 3'h0;
  logic [191:0] use_v = '0, inv_v = '0, and_v = '0;
  integer       n_mismatch = 0, checked = 0, i, k;
  always #2 mclk = ~mclk;
  ttled_src src (.mclk(mclk), .req(req), .logic_bits(bits), .trip_in(trip),
    .target_reset_pb(pb), .close_in(cls));
  ttled_top uut (.mclk(mclk), .rst_b(rst_b), .logic_bits(bits), .term_use(use_v),
    .term_inv(inv_v), .term_and(and_v), .led_latch_mode_select(mode),
    .reset_on_close_sel(roc), .trip_in(trip), .target_reset_pb(pb), .close_in(cls),
    .control_enabled_in(ce), .phase_fault_in(ph), .led_out_q(),
    .control_enabled_led_q(), .phase_target_led_q());
  function automatic logic cnd(input logic [15:0] b, input integer j);
    if (j == 10) return b[13] & (b[10] | b[14]);
    if (j == 11) return ~b[11] & b[12];
    return b[j] ^ j[0];
  endfunction
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task ev(input logic [18:0] r);
    logic [18:0] p;
    p = req;
    req = r;
    repeat (10) @(posedge mclk);
    #1;
    if (r[16] & !p[16]) for (k = 0; k < 12; k++) lat[k] = cnd(r[15:0], k);
    else if (r[17] & !p[17]) lat = 12'h000;
    else if (r[18] & !p[18] & roc[1]) lat = 12'h000;
    for (k = 0; k < 12; k++) xl[k] = mode[k] ? lat[k] : cnd(r[15:0], k);
    chk({4'h0, uut.led_out_q}, {4'h0, xl});
    chk({12'h000, uut.control_enabled_led_q, uut.phase_target_led_q}, {12'h000, ce, ph});
  endtask
  task close_out;
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    i = $urandom(32'h8fe49d50);
    for (k = 0; k < 12; k++) begin
      use_v[16*k+k] = 1'b1;
      inv_v[16*k+k] = k[0];
    end
    {use_v[16*10+14], use_v[16*10+13], and_v[16*10+13]} = 3'h7;
    {use_v[16*11+12], and_v[16*11+12], and_v[16*11+11]} = 3'h7;
    repeat (10) @(posedge mclk);
    #1 rst_b = 1;
    mode = 12'hfff;
    ev(19'h10fff);
    ev(19'h10000);
    ev(19'h40000);
    ev(19'h20000);
    ev(19'h10fff);
    roc = 2'h2;
    ev(19'h40fff);
    mode = 12'h000;
    ev(19'h00a5a);
    ev(19'h1735c);
    for (i = 0; i < 64; i++) begin
      if (i % 16 == 0) begin
        mode = 12'($urandom);
        roc = 2'(i / 16);
      end
      {ce, ph} = 4'($urandom);
      ev(19'($urandom));
    end
    close_out();
  end
endmodule
`default_nettype wire
